// ==== hw/ckr_map.svh ====
`ifndef CKR_MAP_SVH
`define CKR_MAP_SVH
// register byte addresses
`define CKR_ADDR_TEST_STOP 8'h06
`define CKR_ADDR_REV_MAKER 8'h07
`define CKR_ADDR_REQ_MAP 8'h08
`define CKR_ADDR_SPREAD_CFG 8'h09
// byte 6 field positions
`define CKR_B6_TEST_SEL 7
`define CKR_B6_TEST_MODE 6
`define CKR_B6_REF_DRIVE 4
`define CKR_B6_SW_HALT_N 3
// byte 8 field positions
`define CKR_B8_B_PAIR7 7
`define CKR_B8_B_PAIR5 6
`define CKR_B8_B_PAIR3 5
`define CKR_B8_B_PAIR1 4
`define CKR_B8_A_PAIR4 2
`define CKR_B8_A_PAIR2 1
// byte 9 field positions
`define CKR_B9_PROFILE_HI 7
`define CKR_B9_PROFILE_LO 4
`define CKR_B9_FREQ_SEL 3
`define CKR_B9_ENABLE 2
`define CKR_B9_SPREAD_EN 1
`define CKR_B9_SW_SOURCE 0
// reset values of the writable bytes
`define CKR_RST_B6 8'h18
`define CKR_RST_B8 8'h44
`define CKR_RST_B9 8'h0E
// writable masks: reserved bits stay zero
`define CKR_WMASK_B6 8'hD8
`define CKR_WMASK_B8 8'hF6
// identity byte, value arbitrary
`define CKR_REV_MAKER_ID 8'h5A
// pair mask width and all-zero pair mask
`define CKR_PAIRS 7
`define CKR_ZERO_PAIRS 7'h00
// bit index of each pin-mapped pair (1 to 5 and 7) in the halt and map vectors (bit k is pair k+1)
`define CKR_PAIR1_IDX 0
`define CKR_PAIR2_IDX 1
`define CKR_PAIR3_IDX 2
`define CKR_PAIR4_IDX 3
`define CKR_PAIR5_IDX 4
`define CKR_PAIR7_IDX 6
// request pin index in the debounce vectors
`define CKR_REQ_A 0
`define CKR_REQ_B 1
`endif

// ==== hw/ckr_pkg.sv ====
package ckr_pkg;
	// strap capture state
	typedef enum logic [1:0] {
		CKR_WAIT_GOOD,
		CKR_CAPTURED
	} ckr_strap_state_type;

	// host register access
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ckr_reg_req_type;

	// spreadable output controls
	typedef struct packed {
		logic [3:0] profile;
		logic freq_100;
		logic enable;
		logic spread_on;
	} ckr_alt_ctrl_type;

	// whole block state
	typedef struct packed {
		logic [7:0] b6_reg;
		logic [7:0] b8_reg;
		logic [7:0] b9_reg;
		logic [2:0] strap_reg;
		ckr_strap_state_type strap_st_reg;
		logic [7:0] rdata_reg;
		logic [1:0] req_s1_reg;
		logic [1:0] req_s2_reg;
		logic [1:0] req_ok_reg;
		logic [6:0] halt_mask_reg;
		logic test_mode_reg;
		logic test_sel_reg;
		logic ref_high_reg;
		ckr_alt_ctrl_type alt_reg;
	} ckr_state_type;
endpackage

// ==== hw/ckr_ctrl_regs.sv ====
`timescale 1ns/1ps
`include "ckr_map.svh"
// Notes on behaviour
// RL1: byte 6 bit 6 enters test mode
// RL2: test mode: bit 7 picks tri-state or divided
// RL3: byte 6 bit 4 sets reference drive
// RL4: clearing byte 6 bit 3 halts stoppable outputs
// RL5: setting it resumes them; resets to one
// RL6: byte 6 low bits hold captured straps
// RL7: byte 8 high bits map pin B pairs
// RL8: byte 8 bits 2,1 map pin A pairs
// RL9: byte 9 high nibble picks spread profile
// RL10: byte 9 bit 3 picks 96 or 100
// RL11: byte 9 bit 2 enables spreadable output
// RL12: byte 9 bit 1 enables spread modulation
// RL13: byte 9 bit 0 picks software source
// RL14: hardware source used when bit 0 clear
// RL15: request pin accepted after two stable samples
// RL16: deasserted request stops mapped pairs low
module ckr_ctrl_regs (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input ckr_pkg::ckr_reg_req_type req_i,
	input wire logic link_edge_i,
	input wire logic [2:0] freq_strap_i,
	input wire logic power_good_strobe_n_i,
	input wire logic clock_request_pin_a_n_i,
	input wire logic clock_request_pin_b_n_i,
	input wire logic hw_freq_100_i,
	input wire logic [6:0] free_run_mask_i,
	output logic [7:0] rdata_o,
	output logic test_mode_o,
	output logic test_sel_o,
	output logic ref_high_drive_o,
	output logic [6:0] pair_halt_o,
	output ckr_pkg::ckr_alt_ctrl_type alt_ctrl_o
);
	// whole block state in one struct: one process builds the next value,
	// one clocked process registers it
	ckr_pkg::ckr_state_type state_reg;
	ckr_pkg::ckr_state_type state_next;

	// masked byte write helper
	function automatic logic [7:0] ckr_merge(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask);
		ckr_merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	// register byte address match, shared by the write and read decoders
	function automatic logic ckr_hit(input logic [7:0] addr, input logic [7:0] target);
		ckr_hit = (addr == target);
	endfunction

	// reset image of the whole state, control copies derived from the byte reset values;
	// read data, debounce samples and halt mask start at zero, so pins count as asserted
	function automatic ckr_pkg::ckr_state_type ckr_reset_state();
		ckr_pkg::ckr_state_type s;
		logic [7:0] b6;
		logic [7:0] b9;
		s = '0;
		b6 = `CKR_RST_B6;
		b9 = `CKR_RST_B9;
		s.b6_reg = b6;
		s.b8_reg = `CKR_RST_B8;
		s.b9_reg = b9;
		s.strap_st_reg = ckr_pkg::CKR_WAIT_GOOD;
		s.test_mode_reg = b6[`CKR_B6_TEST_MODE];
		s.test_sel_reg = b6[`CKR_B6_TEST_SEL];
		s.ref_high_reg = b6[`CKR_B6_REF_DRIVE];
		s.alt_reg.profile = b9[`CKR_B9_PROFILE_HI:`CKR_B9_PROFILE_LO];
		s.alt_reg.freq_100 = b9[`CKR_B9_FREQ_SEL];
		s.alt_reg.enable = b9[`CKR_B9_ENABLE];
		s.alt_reg.spread_on = b9[`CKR_B9_SPREAD_EN];
		return s;
	endfunction

	// pin B map: byte 8 bits 7 to 4 select pairs 7, 5, 3 and 1
	function automatic logic [6:0] ckr_map_b(input logic [7:0] b8);
		logic [6:0] m;
		m = `CKR_ZERO_PAIRS;
		m[`CKR_PAIR7_IDX] = b8[`CKR_B8_B_PAIR7];
		m[`CKR_PAIR5_IDX] = b8[`CKR_B8_B_PAIR5];
		m[`CKR_PAIR3_IDX] = b8[`CKR_B8_B_PAIR3];
		m[`CKR_PAIR1_IDX] = b8[`CKR_B8_B_PAIR1];
		return m;
	endfunction

	// pin A map: byte 8 bits 2 and 1 select pairs 4 and 2
	function automatic logic [6:0] ckr_map_a(input logic [7:0] b8);
		logic [6:0] m;
		m = `CKR_ZERO_PAIRS;
		m[`CKR_PAIR4_IDX] = b8[`CKR_B8_A_PAIR4];
		m[`CKR_PAIR2_IDX] = b8[`CKR_B8_A_PAIR2];
		return m;
	endfunction

	// combined halt mask: the software halt spares free pairs,
	// a released request pin halts only the pairs mapped to it
	function automatic logic [6:0] ckr_halt(input logic sw_halt_n, input logic [6:0] free_mask,
		input logic [1:0] released, input logic [6:0] map_a, input logic [6:0] map_b);
		logic [6:0] h;
		h = `CKR_ZERO_PAIRS;
		if (!sw_halt_n) begin
			h = ~free_mask; // [RL4]
		end
		if (released[`CKR_REQ_A]) begin
			h = h | map_a; // [RL16]
		end
		if (released[`CKR_REQ_B]) begin
			h = h | map_b; // [RL16]
		end
		return h;
	endfunction

	// next-state logic for registers, straps, request pins and halt mask
	always_comb begin
		logic [6:0] mask_a;
		logic [6:0] mask_b;
		logic [6:0] halt;
		mask_a = `CKR_ZERO_PAIRS;
		mask_b = `CKR_ZERO_PAIRS;
		halt = `CKR_ZERO_PAIRS;
		state_next = state_reg;
		// host writes; the identity byte and unmapped addresses fall through and are dropped
		if (req_i.wr) begin
			if (ckr_hit(req_i.addr, `CKR_ADDR_TEST_STOP)) begin
				// strap bits and the reserved bit are outside the mask and stay as they are
				state_next.b6_reg = ckr_merge(state_reg.b6_reg, req_i.wdata,
					`CKR_WMASK_B6); // [RL1] [RL2] [RL3] [RL4] [RL5]
			end else if (ckr_hit(req_i.addr, `CKR_ADDR_REQ_MAP)) begin
				// reserved bits are masked off and always read zero
				state_next.b8_reg = ckr_merge(state_reg.b8_reg, req_i.wdata,
					`CKR_WMASK_B8); // [RL7] [RL8]
			end else if (ckr_hit(req_i.addr, `CKR_ADDR_SPREAD_CFG)) begin
				state_next.b9_reg = req_i.wdata; // [RL9] [RL10] [RL11] [RL12] [RL13]
			end
		end

		// host reads; unmapped reads return zero
		// a read in the same cycle as a write returns the byte as it was before the write
		if (req_i.rd) begin
			if (ckr_hit(req_i.addr, `CKR_ADDR_TEST_STOP)) begin
				state_next.rdata_reg = {state_reg.b6_reg[`CKR_B6_TEST_SEL:`CKR_B6_SW_HALT_N],
					state_reg.strap_reg}; // [RL6]
			end else if (ckr_hit(req_i.addr, `CKR_ADDR_REV_MAKER)) begin
				state_next.rdata_reg = `CKR_REV_MAKER_ID;
			end else if (ckr_hit(req_i.addr, `CKR_ADDR_REQ_MAP)) begin
				state_next.rdata_reg = state_reg.b8_reg;
			end else if (ckr_hit(req_i.addr, `CKR_ADDR_SPREAD_CFG)) begin
				state_next.rdata_reg = state_reg.b9_reg;
			end else begin
				state_next.rdata_reg = 8'h00;
			end
		end

		// straps latched once while power good strobe is low
		case (state_reg.strap_st_reg)
			ckr_pkg::CKR_WAIT_GOOD: begin
				if (!power_good_strobe_n_i) begin
					state_next.strap_reg = freq_strap_i; // [RL6]
					state_next.strap_st_reg = ckr_pkg::CKR_CAPTURED;
				end
			end
			default: begin
				state_next.strap_st_reg = ckr_pkg::CKR_CAPTURED;
			end
		endcase

		// request pins debounced on link edges: s1 is the newest sample, s2 the one before;
		// a level is only accepted when both agree, so a pin bouncing between two link
		// edges never reaches the halt mask
		if (link_edge_i) begin
			state_next.req_s1_reg = {clock_request_pin_b_n_i, clock_request_pin_a_n_i};
			state_next.req_s2_reg = state_reg.req_s1_reg;
			if (state_reg.req_s1_reg == state_reg.req_s2_reg) begin
				state_next.req_ok_reg = state_reg.req_s2_reg; // [RL15]
			end
		end

		// pair maps from byte 8
		mask_b = ckr_map_b(state_reg.b8_reg); // [RL7]
		mask_a = ckr_map_a(state_reg.b8_reg); // [RL8]

		// halt: software halt for non-free pairs, released pins for their mapped pairs
		halt = ckr_halt(state_reg.b6_reg[`CKR_B6_SW_HALT_N], free_run_mask_i,
			state_reg.req_ok_reg, mask_a, mask_b); // [RL4] [RL16]
		// halt changes only on link edge so stops are whole periods
		if (link_edge_i) begin
			state_next.halt_mask_reg = halt; // [RL4] [RL5] [RL16]
		end

		// control copies lag their register byte by one edge, so every control output
		// is a plain flip-flop; a write therefore shows on the pins one edge after
		// it is taken
		state_next.test_mode_reg = state_reg.b6_reg[`CKR_B6_TEST_MODE]; // [RL1]
		state_next.test_sel_reg = state_reg.b6_reg[`CKR_B6_TEST_SEL]; // [RL2]
		state_next.ref_high_reg = state_reg.b6_reg[`CKR_B6_REF_DRIVE]; // [RL3]
		state_next.alt_reg.profile =
			state_reg.b9_reg[`CKR_B9_PROFILE_HI:`CKR_B9_PROFILE_LO]; // [RL9]
		state_next.alt_reg.enable = state_reg.b9_reg[`CKR_B9_ENABLE]; // [RL11]
		state_next.alt_reg.spread_on = state_reg.b9_reg[`CKR_B9_SPREAD_EN]; // [RL12]
		// frequency source: software select bit only counts while the source bit is set,
		// otherwise the hardware level is followed
		if (state_reg.b9_reg[`CKR_B9_SW_SOURCE]) begin
			state_next.alt_reg.freq_100 = state_reg.b9_reg[`CKR_B9_FREQ_SEL]; // [RL10] [RL13]
		end else begin
			state_next.alt_reg.freq_100 = hw_freq_100_i; // [RL14]
		end
	end

	// state register with synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= ckr_reset_state(); // [RL1] [RL3] [RL5] [RL11] [RL12] [RL13]
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from flip-flops
	assign rdata_o = state_reg.rdata_reg;
	assign test_mode_o = state_reg.test_mode_reg;
	assign test_sel_o = state_reg.test_sel_reg;
	assign ref_high_drive_o = state_reg.ref_high_reg;
	assign pair_halt_o = state_reg.halt_mask_reg;
	assign alt_ctrl_o = state_reg.alt_reg;
endmodule

// ==== bench/ckr_link_model.sv ====
`timescale 1ns/1ps
// far side: one link-clock rising edge every four core cycles
module ckr_link_model (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	output logic link_edge_o
);
	logic [1:0] cnt_reg;
	// divider keeps running whenever reset is released
	always_ff @(posedge core_clk_i) begin
		cnt_reg <= rst_n_i ? cnt_reg + 2'h1 : 2'h0;
	end
	assign link_edge_o = (cnt_reg == 2'h3);
endmodule

// ==== bench/ckr_ctrl_regs_assertions.sv ====
`timescale 1ns/1ps
module ckr_chk (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input ckr_pkg::ckr_reg_req_type req_i,
	input wire logic link_edge_i,
	input wire logic [7:0] rdata_o,
	input wire logic test_mode_o,
	input wire logic test_sel_o,
	input wire logic ref_high_drive_o,
	input wire logic [6:0] pair_halt_o,
	input ckr_pkg::ckr_alt_ctrl_type alt_ctrl_o
);
	logic w6, w9;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// host writes to the control bytes
	assign w6 = req_i.wr && req_i.addr == 8'h06;
	assign w9 = req_i.wr && req_i.addr == 8'h09;
	AST_TEST_MODE: assert property (w6 |-> ##2 test_mode_o == $past(req_i.wdata[6], 2))
		else $error("test mode wrong");
	AST_TEST_SEL: assert property (w6 |-> ##2 test_sel_o == $past(req_i.wdata[7], 2))
		else $error("test select wrong");
	AST_REF_DRIVE: assert property (w6 |-> ##2 ref_high_drive_o == $past(req_i.wdata[4], 2))
		else $error("drive strength wrong");
	AST_HALT_SYNC: assert property ($changed(pair_halt_o) |-> $past(link_edge_i))
		else $error("halt off link edge");
	AST_PROFILE: assert property (w9 |-> ##2 alt_ctrl_o.profile == $past(req_i.wdata[7:4], 2))
		else $error("profile wrong");
	AST_ALT_EN: assert property (w9 |-> ##2 alt_ctrl_o.enable == $past(req_i.wdata[2], 2))
		else $error("enable wrong");
	AST_SPREAD: assert property (w9 |-> ##2 alt_ctrl_o.spread_on == $past(req_i.wdata[1], 2))
		else $error("spread wrong");
	AST_MAP_RSVD: assert property (req_i.rd && req_i.addr == 8'h08 |=> rdata_o[3] == 1'b0 && rdata_o[0] == 1'b0)
		else $error("reserved bits set");
	cover property (w6);
	cover property (w9);
	cover property ($rose(|pair_halt_o));
endmodule
bind ckr_ctrl_regs ckr_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
	.link_edge_i(link_edge_i), .rdata_o(rdata_o), .test_mode_o(test_mode_o), .test_sel_o(test_sel_o),
	.ref_high_drive_o(ref_high_drive_o), .pair_halt_o(pair_halt_o), .alt_ctrl_o(alt_ctrl_o));

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	ckr_pkg::ckr_reg_req_type req = '0;
	logic lnk, pg_n = 1'b1, pa_n = 1'b0, pb_n = 1'b0, hw = 1'b0, ts, tm, rh;
	logic [6:0] fm = 7'h00, halt;
	logic [7:0] rdata, v;
	ckr_pkg::ckr_alt_ctrl_type alt;
	int error_cnt = 0;
	int cmp_count = 0;
	// addr, wdata, read back, {sel, mode, ref, alt}
	// hardware frequency level starts low and byte 9 bit 0 is clear except after the FF write, so freq_100 reads 0 except in that row
	logic [33:0] rows [7] = '{{8'h06, 8'hFF, 8'hDD, 10'h383}, {8'h06, 8'h00, 8'h05, 10'h003},
		{8'h08, 8'hFF, 8'hF6, 10'h003}, {8'h08, 8'h00, 8'h00, 10'h003},
		{8'h09, 8'hFF, 8'hFF, 10'h07F}, {8'h09, 8'h5A, 8'h5A, 10'h029}, {8'h07, 8'h00, 8'h5A, 10'h029}};
	logic [15:0] dflt [4] = '{16'h061D, 16'h0844, 16'h090E, 16'h075A};
	always #2.5 core_clk_i = ~core_clk_i;
	ckr_link_model u_link (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_edge_o(lnk));
	ckr_ctrl_regs uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req), .link_edge_i(lnk),
		.freq_strap_i(3'h5), .power_good_strobe_n_i(pg_n), .clock_request_pin_a_n_i(pa_n),
		.clock_request_pin_b_n_i(pb_n), .hw_freq_100_i(hw), .free_run_mask_i(fm), .rdata_o(rdata),
		.test_mode_o(tm), .test_sel_o(ts), .ref_high_drive_o(rh), .pair_halt_o(halt), .alt_ctrl_o(alt));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i) req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk_i) req <= '0;
		@(posedge core_clk_i) #1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk_i) req <= '0;
		#1 v = rdata;
	endtask
	task automatic do_reset();
		rst_n_i <= 1'b0;
		pg_n <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		pg_n <= 1'b0;
	endtask
	task automatic wait_chk(input int n, input logic [6:0] e);
		repeat (n) @(posedge core_clk_i);
		#1 `CK(halt, e)
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence: table rows, then frequency source, halts, reset and request pins
	initial begin
		do_reset();
		foreach (rows[i]) begin
			wr(rows[i][33:26], rows[i][25:18]);
			`CK({ts, tm, rh, alt}, rows[i][9:0])
			rd(rows[i][33:26]);
			`CK(v, rows[i][17:10])
		end
		@(posedge core_clk_i) hw <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 `CK(alt.freq_100, 1'b1)
		wr(8'h09, 8'h01);
		`CK(alt.freq_100, 1'b0)
		@(posedge core_clk_i) fm <= 7'h01;
		wait_chk(12, 7'h7E);
		wr(8'h06, 8'h18);
		wait_chk(12, 7'h00);
		@(posedge core_clk_i) do_reset();
		@(posedge core_clk_i) #1 `CK({ts, tm, rh, alt}, 10'h087)
		foreach (dflt[i]) begin
			rd(dflt[i][15:8]);
			`CK(v, dflt[i][7:0])
		end
		@(posedge core_clk_i) pa_n <= 1'b1;
		pb_n <= 1'b1;
		wait_chk(3, 7'h00);
		wait_chk(16, 7'h18);
		@(posedge core_clk_i) pa_n <= 1'b0;
		pb_n <= 1'b0;
		wait_chk(16, 7'h00);
		print_verdict();
	end
	// watchdog against a hung sequence
	initial begin
		#15000;
		error_cnt++;
		print_verdict();
	end
endmodule
